// *** core/sep_eeprom_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: host holds the pause input high unless deliberately pausing a transfer.
// RULE2: pause starts when pause falls with SCK low, else at next SCK fall.
// RULE3: while paused SI and SCK are ignored and sequence state is kept.
// RULE4: resume when pause rises with SCK low, else at next SCK fall.
// RULE5: SO released on pause fall, driven again on pause rise, any SCK level.
// RULE6: opcode shifted in on SCK rising edges from first edge after select.
// RULE7: opcodes, addresses and data travel MSB first both ways.
// RULE8: 0x03 starts array read, 0x02 starts array write at following address.
// RULE9: 0x06 sets the write latch, 0x04 clears it.
// RULE10: 0x05 shifts out status byte, accepted even during an internal write.
// RULE11: read is opcode, 16-bit address with top bit ignored, then data out.
// RULE12: sequential read increments address per byte, 7FFF wraps to 0000.
// RULE13: latch sets only when select rises after all eight opcode bits.
// RULE14: write is opcode, 16-bit address, then 1 to 64 data bytes.
// RULE15: page write wraps low address bits within the same 64-byte page.
// RULE16: write commits only if select rises right after a complete byte.
// RULE17: array reads are refused during an internal write; status reads answered.
// RULE18: array or status write refused unless write latch is set.
// RULE19: latch cleared at reset, disable, status write and array write completion.
// RULE20: status: bit7 pin enable, 3..2 block guards, 1 latch, 0 busy.
// RULE21: busy reads 1 during internal write, writes to it have no effect.
// RULE22: latch commands update the latch even when status is protected.
// RULE23: block guards kept over power cycles, changed only by status write.
// RULE24: select rising after valid write starts internal write, which always finishes.
// RULE25: pin enable set and protect pin low blocks status nonvolatile writes.
// RULE26: block guards protect none, upper quarter, upper half or whole array.
// RULE27: unknown opcode ignored until deselect, SO stays released, state kept.
module sep_eeprom_port
   import sep_pkg::*;
#(
   parameter int TWC_CYCLES = SEP_TWC_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic si_pin,
   input wire logic pause_n_pin,
   input wire logic wp_n_pin,
   output logic so_out,
   output logic so_oe,
   output logic busy_writing
);
   // two-flop synchronisers for all pins
   logic [4:0] meta_r;
   logic [4:0] sync_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= 5'h13; // idle levels: deselected, SCK low, not paused
         sync_r <= 5'h13;
      end else if (clk_en) begin
         meta_r <= {cs_n_pin, sck_pin, si_pin, pause_n_pin, wp_n_pin};
         sync_r <= meta_r;
      end
   end
   logic cs_n, sck, si, pause_n, wp_n;
   assign {cs_n, sck, si, pause_n, wp_n} = sync_r;

   // edge detection on synchronised pins
   logic sck_d_r, cs_d_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else if (clk_en) begin
         sck_d_r <= sck;
         cs_d_r <= cs_n;
      end
   end
   logic sck_rise, sck_fall, cs_rise;
   assign sck_rise = sck & ~sck_d_r;
   assign sck_fall = ~sck & sck_d_r;
   assign cs_rise = cs_n & ~cs_d_r;

   // pause state: enter or leave while SCK is low; deselect leaves it at any SCK level
   logic paused_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         paused_r <= 1'b0;
      end else if (clk_en) begin
         if (cs_n) begin
            paused_r <= 1'b0;
         end else if (pause_n == paused_r && (!sck || sck_fall)) begin
            paused_r <= ~pause_n; // RULE2 RULE4
         end
      end
   end
   logic act_rise, act_fall;
   assign act_rise = sck_rise & ~paused_r & ~cs_n; // RULE3
   assign act_fall = sck_fall & ~paused_r & ~cs_n;

   // array storage and status
   logic [7:0] mem_r [SEP_MEM_BYTES];
   logic [7:0] page_r [2**SEP_PAGE_W];
   logic [2**SEP_PAGE_W-1:0] page_vld_r;
   logic ppe_r, wlf_r;
   logic [1:0] bg_r;
   logic busy_r;
   logic [31:0] twc_cnt_r;

   function automatic logic sep_guarded(input logic [1:0] bg, input logic [14:0] a);
      if (bg == SEP_BG_NONE) begin
         sep_guarded = 1'b0;
      end else if (bg == SEP_BG_QUARTER) begin
         sep_guarded = a >= SEP_QUARTER_BASE;
      end else if (bg == SEP_BG_HALF) begin
         sep_guarded = a >= SEP_HALF_BASE;
      end else begin
         sep_guarded = 1'b1;
      end
   endfunction // RULE26

   // serial sequencer
   sep_state_t st_r;
   logic [7:0] sh_r;
   logic [2:0] bit_r;
   logic [1:0] abyte_r;
   logic [7:0] op_r;
   logic [14:0] addr_r;
   logic [7:0] out_r;
   logic byte_done_r;
   logic [7:0] sr_new_r;
   logic [7:0] sh_in;
   logic [7:0] status_byte;
   assign sh_in = {sh_r[6:0], si}; // RULE7
   assign status_byte = {ppe_r, 3'h0, bg_r, wlf_r, busy_r}; // RULE20 RULE21

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= SEP_ST_OPCODE;
         sh_r <= 8'h00;
         bit_r <= 3'h0;
         abyte_r <= 2'h0;
         op_r <= 8'h00;
         addr_r <= 15'h0000;
         byte_done_r <= 1'b0;
         sr_new_r <= 8'h00;
      end else if (clk_en) begin
         if (cs_n) begin
            st_r <= SEP_ST_OPCODE;
            bit_r <= 3'h0;
            abyte_r <= 2'h0;
            byte_done_r <= 1'b0;
         end else if (act_rise) begin
            sh_r <= sh_in; // RULE6
            bit_r <= bit_r + 3'h1;
            byte_done_r <= (bit_r == SEP_BIT_LAST);
            if (st_r == SEP_ST_DONE) begin
               // any bit after a complete command cancels it
               st_r <= SEP_ST_IGNORE; // RULE13 RULE16
            end else if (bit_r == SEP_BIT_LAST) begin
               case (st_r)
                  SEP_ST_OPCODE: begin
                     op_r <= sh_in;
                     if (sh_in == SEP_OP_READ && !busy_r) begin
                        st_r <= SEP_ST_ADDR; // RULE8 RULE17
                     end else if (sh_in == SEP_OP_WRITE && !busy_r) begin
                        st_r <= SEP_ST_ADDR;
                     end else if (sh_in == SEP_OP_STATUS_READ) begin
                        st_r <= SEP_ST_STATUS_RD; // RULE10
                     end else if (sh_in == SEP_OP_STATUS_WRITE && !busy_r) begin
                        st_r <= SEP_ST_STATUS_WR;
                     end else if ((sh_in == SEP_OP_LATCH_ENABLE || sh_in == SEP_OP_LATCH_DISABLE) && !busy_r) begin
                        st_r <= SEP_ST_DONE;
                     end else begin
                        st_r <= SEP_ST_IGNORE; // RULE27
                     end
                  end
                  SEP_ST_ADDR: begin
                     addr_r <= {addr_r[6:0], sh_in}; // RULE11
                     abyte_r <= abyte_r + 2'h1;
                     if (abyte_r + 2'h1 == SEP_ADDR_BYTES) begin
                        st_r <= (op_r == SEP_OP_READ) ? SEP_ST_READ : SEP_ST_WRITE; // RULE14
                     end
                  end
                  SEP_ST_READ: begin
                     addr_r <= addr_r + SEP_ADDR_ONE; // RULE12
                  end
                  SEP_ST_WRITE: begin
                     // wrap within page
                     addr_r[SEP_PAGE_W-1:0] <= addr_r[SEP_PAGE_W-1:0] + 6'h01; // RULE15
                  end
                  SEP_ST_STATUS_WR: begin
                     sr_new_r <= sh_in;
                     st_r <= SEP_ST_DONE;
                  end
                  default: begin
                     st_r <= st_r;
                  end
               endcase
            end
         end
      end
   end

   // page buffer collects data bytes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         page_vld_r <= '0;
      end else if (clk_en) begin
         if (st_r == SEP_ST_OPCODE && !cs_n && bit_r == 3'h0 && !busy_r) begin
            page_vld_r <= '0;
         end else if (act_rise && bit_r == SEP_BIT_LAST && st_r == SEP_ST_WRITE) begin
            page_r[addr_r[SEP_PAGE_W-1:0]] <= sh_in;
            page_vld_r[addr_r[SEP_PAGE_W-1:0]] <= 1'b1;
         end
      end
   end

   // commit decision at select rise
   logic commit_ok;
   logic wr_commit, sr_commit, en_commit, dis_commit;
   logic sr_locked;
   assign commit_ok = cs_rise && bit_r == 3'h0 && byte_done_r; // RULE16 RULE13
   assign sr_locked = ppe_r & ~wp_n; // RULE25
   assign wr_commit = commit_ok && st_r == SEP_ST_WRITE && wlf_r && |page_vld_r; // RULE18 RULE24
   assign sr_commit = commit_ok && st_r == SEP_ST_DONE && op_r == SEP_OP_STATUS_WRITE && wlf_r && !sr_locked;
   assign en_commit = commit_ok && st_r == SEP_ST_DONE && op_r == SEP_OP_LATCH_ENABLE; // RULE22
   assign dis_commit = commit_ok && st_r == SEP_ST_DONE && op_r == SEP_OP_LATCH_DISABLE;

   // status bits, write latch and internal write timer
   logic [14:0] pg_base_r;
   logic [SEP_PAGE_W:0] prog_idx_r;
   logic prog_arr_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wlf_r <= 1'b0; // RULE19
         busy_r <= 1'b0;
         prog_arr_r <= 1'b0;
         twc_cnt_r <= 32'h0000_0000;
         pg_base_r <= 15'h0000;
         prog_idx_r <= '0;
      end else if (clk_en) begin
         if (en_commit) begin
            wlf_r <= 1'b1; // RULE9
         end else if (dis_commit || sr_commit || (busy_r && twc_cnt_r == 32'h0000_0001)) begin
            wlf_r <= 1'b0; // RULE19
         end
         if (wr_commit || sr_commit) begin
            busy_r <= 1'b1;
            twc_cnt_r <= 32'(TWC_CYCLES);
            prog_arr_r <= wr_commit; // later opcodes must not stop programming
            pg_base_r <= {addr_r[14:SEP_PAGE_W], 6'h00};
            prog_idx_r <= '0;
         end else if (busy_r) begin
            twc_cnt_r <= twc_cnt_r - 32'h0000_0001; // RULE24
            if (twc_cnt_r == 32'h0000_0001) begin
               busy_r <= 1'b0;
            end
            if (!prog_idx_r[SEP_PAGE_W]) begin
               prog_idx_r <= prog_idx_r + 1'b1;
            end
         end
      end
   end

   // block guards are nonvolatile: no reset, changed only by status write
   always_ff @(posedge clk) begin
      if (clk_en && sr_commit) begin
         ppe_r <= sr_new_r[SEP_SR_PPE];
         bg_r <= {sr_new_r[SEP_SR_BGH], sr_new_r[SEP_SR_BGL]}; // RULE23
      end
   end

   // array programming: one page slot per cycle, guarded addresses skipped
   logic [14:0] prog_addr;
   assign prog_addr = pg_base_r | {9'h000, prog_idx_r[SEP_PAGE_W-1:0]};
   always_ff @(posedge clk) begin
      if (clk_en && busy_r && !prog_idx_r[SEP_PAGE_W] && prog_arr_r &&
         page_vld_r[prog_idx_r[SEP_PAGE_W-1:0]] && !sep_guarded(bg_r, prog_addr)) begin
         mem_r[prog_addr] <= page_r[prog_idx_r[SEP_PAGE_W-1:0]];
      end
   end

   // output shifter loads a byte at each byte start and shifts on SCK fall
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_r <= 8'h00;
      end else if (clk_en) begin
         if (act_fall && bit_r == 3'h0 && st_r == SEP_ST_READ) begin
            out_r <= mem_r[addr_r];
         end else if (act_fall && bit_r == 3'h0 && st_r == SEP_ST_STATUS_RD) begin
            out_r <= status_byte;
         end else if (act_fall) begin
            out_r <= {out_r[6:0], 1'b0}; // RULE7
         end
      end
   end

   // SO drive follows synchronised pause level one clock later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         so_oe <= 1'b0;
         so_out <= 1'b0;
      end else if (clk_en) begin
         so_oe <= !cs_n && pause_n && (st_r == SEP_ST_READ || st_r == SEP_ST_STATUS_RD); // RULE5 RULE27
         so_out <= out_r[7];
      end
   end
   assign busy_writing = busy_r;

   AST_PAUSE_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && paused_r && !cs_n && sck_rise) |=> $stable(st_r) && $stable(bit_r)) // RULE3
      else $error("sequence moved while paused");
   AST_SO_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && !pause_n) |=> !so_oe) // RULE5
      else $error("SO driven while paused");
   AST_LATCH_SET: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && en_commit) |=> wlf_r) // RULE9
      else $error("latch not set");
   AST_LATCH_REQ: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && !wlf_r && !busy_r) |=> !busy_r) // RULE18
      else $error("write started without latch");
   AST_BUSY_START: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && wr_commit) |=> busy_r && twc_cnt_r == 32'(TWC_CYCLES)) // RULE21 RULE24
      else $error("write cycle did not start");
   AST_NO_READ_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && busy_r && st_r == SEP_ST_OPCODE) |=> st_r != SEP_ST_READ) // RULE17
      else $error("array read while busy");
   AST_SR_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && sr_locked) |-> !sr_commit) // RULE25
      else $error("status written while protected");
   AST_IGNORE_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && st_r == SEP_ST_IGNORE && !cs_n) |=> (st_r == SEP_ST_IGNORE || cs_n) && !so_oe) // RULE27
      else $error("ignored opcode acted");
   // pause entry and exit follow the synchronised SCK low level
   AST_PAUSE_ENTER: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
      (clk_en && !cs_n && !pause_n && !sck && !paused_r) |=> paused_r)
      else $error("pause not entered");
   AST_PAUSE_LEAVE: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      (clk_en && !cs_n && pause_n && !sck && paused_r) |=> !paused_r)
      else $error("pause not left");
   AST_CYCLE_END: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
      (clk_en && busy_r && twc_cnt_r == 32'h0000_0001) |=> !busy_r && !wlf_r)
      else $error("write cycle end did not clear latch");
   AST_DESEL_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
      (clk_en && cs_n) |=> st_r == SEP_ST_OPCODE && !so_oe)
      else $error("sequence kept after deselect");
endmodule
`default_nettype wire

// *** core/sep_pkg.sv ***
package sep_pkg;
   // opcodes
   localparam logic [7:0] SEP_OP_READ = 8'h03;
   localparam logic [7:0] SEP_OP_WRITE = 8'h02;
   localparam logic [7:0] SEP_OP_LATCH_DISABLE = 8'h04;
   localparam logic [7:0] SEP_OP_LATCH_ENABLE = 8'h06;
   localparam logic [7:0] SEP_OP_STATUS_READ = 8'h05;
   localparam logic [7:0] SEP_OP_STATUS_WRITE = 8'h01;
   // array geometry
   localparam int SEP_ADDR_W = 15;
   localparam int SEP_MEM_BYTES = 32768;
   localparam int SEP_PAGE_W = 6;
   localparam logic [14:0] SEP_ADDR_ONE = 15'h0001;
   localparam logic [14:0] SEP_QUARTER_BASE = 15'h6000;
   localparam logic [14:0] SEP_HALF_BASE = 15'h4000;
   // status bit positions
   localparam int SEP_SR_PPE = 7;
   localparam int SEP_SR_BGH = 3;
   localparam int SEP_SR_BGL = 2;
   localparam int SEP_SR_WLF = 1;
   localparam int SEP_SR_BUSY = 0;
   // shift counts
   localparam logic [2:0] SEP_BIT_LAST = 3'h7;
   localparam logic [1:0] SEP_ADDR_BYTES = 2'h2;
   // internal write cycle time, 5 ms at 25 MHz
   localparam int SEP_CLK_HZ = 25000000;
   localparam int SEP_TWC_US = 5000;
   localparam int SEP_TWC_CYC = SEP_CLK_HZ / 1000000 * SEP_TWC_US;
   // block guard encodings
   localparam logic [1:0] SEP_BG_NONE = 2'h0;
   localparam logic [1:0] SEP_BG_QUARTER = 2'h1;
   localparam logic [1:0] SEP_BG_HALF = 2'h2;
   typedef enum logic [2:0] {SEP_ST_OPCODE, SEP_ST_ADDR, SEP_ST_READ, SEP_ST_WRITE,
      SEP_ST_STATUS_RD, SEP_ST_STATUS_WR, SEP_ST_DONE, SEP_ST_IGNORE} sep_state_t;
endpackage

// *** sim/sep_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sep_host_model (
   input wire logic clk,
   input wire logic so_out,
   input wire logic so_oe,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic pause_n
);
   // idle: deselected, clock low, not paused
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      pause_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // select and deselect only with the clock low
   task automatic sel();
      cs_n <= 1'b0;
      tick(4);
   endtask
   task automatic desel();
      sck <= 1'b0;
      si <= ~si;
      tick(4);
      cs_n <= 1'b1;
      tick(6);
   endtask
   // one unit msb first, so sampled late in the high phase
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx, input int nb = 8);
      rx = 8'hzz;
      for (int i = 7; i > 7 - nb; i--) begin
         sck <= 1'b0;
         si <= tx[i];
         tick(4);
         sck <= 1'b1;
         tick(3);
         #1 rx[i] = so_oe ? so_out : 1'bz;
         tick(1);
      end
   endtask
   // pause pin is moved only while the clock is low
   task automatic lo();
      sck <= 1'b0;
      tick(4);
   endtask
   task automatic hold(input logic v);
      pause_n <= v;
      tick(6);
   endtask
endmodule
`default_nettype wire

// *** sim/spi_serial_eeprom_command_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_serial_eeprom_command_port_tb_top;
   import sep_pkg::*;
   localparam int TWC = 400;
   logic clk;
   logic rst_n;
   logic clk_en;
   logic wp_n;
   logic [7:0] rx;
   logic [7:0] st;
   int error_cnt = 0;
   int checked = 0;
   wire logic cs_n;
   wire logic sck;
   wire logic si;
   wire logic pause_n;
   wire logic so_out;
   wire logic so_oe;
   wire logic busy;
   sep_eeprom_port #(.TWC_CYCLES(TWC)) u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cs_n_pin(cs_n),
      .sck_pin(sck), .si_pin(si), .pause_n_pin(pause_n), .wp_n_pin(wp_n), .so_out(so_out), .so_oe(so_oe),
      .busy_writing(busy));
   sep_host_model u_host (.clk(clk), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
      .pause_n(pause_n));
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      results();
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // bus helpers
   task automatic cmd(input logic [7:0] op);
      u_host.sel();
      u_host.xb(op, rx);
      u_host.desel();
   endtask
   task automatic rd_st(output logic [7:0] s);
      u_host.sel();
      u_host.xb(SEP_OP_STATUS_READ, s);
      u_host.xb(8'h00, s);
      u_host.desel();
      s = s & 8'h8f;
   endtask
   task automatic wait_idle();
      int n = 0;
      while (busy !== 1'b0 && n < 2 * TWC) begin
         @(posedge clk);
         n++;
      end
      chk("busy_end", {7'h00, busy}, 8'h00);
   endtask
   task automatic head(input logic [7:0] op, input logic [15:0] a);
      u_host.sel();
      u_host.xb(op, rx);
      u_host.xb(a[15:8], rx);
      u_host.xb(a[7:0], rx);
   endtask
   task automatic wr_st(input logic [7:0] v);
      cmd(SEP_OP_LATCH_ENABLE);
      u_host.sel();
      u_host.xb(SEP_OP_STATUS_WRITE, rx);
      u_host.xb(v, rx);
      u_host.desel();
      wait_idle();
   endtask
   // n data bytes counting up from d, then a partial unit of ex bits
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n, input int ex, input logic en);
      if (en) cmd(SEP_OP_LATCH_ENABLE);
      head(SEP_OP_WRITE, a);
      for (int i = 0; i < n; i++) u_host.xb(d + 8'(i), rx);
      if (ex > 0) u_host.xb(8'hff, rx, ex);
      u_host.desel();
   endtask
   task automatic rd(input string what, input logic [15:0] a, input int n, input logic [7:0] d);
      head(SEP_OP_READ, a);
      for (int i = 0; i < n; i++) begin
         u_host.xb(8'h00, rx);
         chk(what, rx, d + 8'(i));
      end
      u_host.desel();
   endtask
   // scenarios
   task automatic t_latch();
      wr_st(8'h00);
      rd_st(st);
      chk("status_clean", st, 8'h00);
      cmd(SEP_OP_LATCH_ENABLE);
      rd_st(st);
      chk("latch_set", st, 8'h02);
      cmd(SEP_OP_LATCH_DISABLE);
      rd_st(st);
      chk("latch_clr", st, 8'h00);
      u_host.sel();
      u_host.xb(SEP_OP_LATCH_ENABLE, rx);
      wr(16'h0200, 8'h44, 1, 0, 1'b0);
      chk("same_sel", {7'h00, busy}, 8'h00);
      rd_st(st);
      chk("same_sel_latch", st, 8'h00);
      wr(16'h0200, 8'h33, 1, 0, 1'b0);
      chk("no_latch", {7'h00, busy}, 8'h00);
      wr(16'h0200, 8'h33, 1, 3, 1'b1);
      chk("abort", {7'h00, busy}, 8'h00);
      $display("test latch done");
   endtask
   task automatic t_page();
      wr(16'h807e, 8'h10, 3, 0, 1'b1);
      rd_st(st);
      chk("busy_status", st, 8'h03);
      head(SEP_OP_READ, 16'h007e);
      u_host.xb(8'h00, rx);
      chk("read_refused", rx, 8'hzz);
      u_host.desel();
      wait_idle();
      rd_st(st);
      chk("latch_after", st, 8'h00);
      rd("page", 16'h007e, 2, 8'h10);
      rd("page_wrap", 16'h0040, 1, 8'h12);
      wr(16'h7fff, 8'h5a, 1, 0, 1'b1);
      wait_idle();
      wr(16'h0000, 8'h5b, 1, 0, 1'b1);
      wait_idle();
      rd("rollover", 16'h7fff, 2, 8'h5a);
      $display("test page done");
   endtask
   task automatic t_guard();
      wr_st(8'h04);
      rd_st(st);
      chk("guard_set", st, 8'h04);
      wr(16'h7fff, 8'hee, 1, 0, 1'b1);
      wait_idle();
      rd("guarded", 16'h7fff, 1, 8'h5a);
      wr_st(8'h80);
      wp_n <= 1'b0;
      wr_st(8'h8c);
      rd_st(st);
      chk("pin_protect", st & 8'h8d, 8'h80);
      wp_n <= 1'b1;
      wr_st(8'h00);
      $display("test guard done");
   endtask
   task automatic t_pause();
      head(SEP_OP_READ, 16'h007e);
      u_host.xb(8'h00, rx);
      chk("pre_pause", rx, 8'h10);
      u_host.lo();
      u_host.hold(1'b0);
      #1 chk("so_off", {7'h00, so_oe}, 8'h00);
      u_host.tick(1);
      u_host.xb(8'hff, rx);
      chk("paused", rx, 8'hzz);
      u_host.lo();
      u_host.hold(1'b1);
      #1 chk("so_on", {7'h00, so_oe}, 8'h01);
      u_host.tick(1);
      u_host.xb(8'h00, rx);
      chk("resumed", rx, 8'h11);
      u_host.desel();
      head(8'ha5, 16'h0000);
      chk("unknown_op", rx, 8'hzz);
      u_host.desel();
      rd_st(st);
      chk("unknown_state", st, 8'h00);
      $display("test pause done");
   endtask
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      wp_n = 1'b1;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_latch();
      t_page();
      t_guard();
      t_pause();
      results();
   end
endmodule
`default_nettype wire
